// >>> hw/afesc_top.sv
// serial control port, register set and pixel path control of the front end
`timescale 1ns/10ps
`include "afesc_consts.svh"
module afesc_top
  import afesc_pkg::*;
#(
  parameter int unsigned DW = 12
)(
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire logic          serial_clk,
  input  wire logic          serial_data_in,
  input  wire logic          write_strobe,
  input  wire logic          chip_select_pin_low,
  input  wire logic          chip_select_pin_high,
  output logic               read_output_pin,
  input  wire logic          reference_sample_pulse,
  input  wire logic          data_sample_pulse,
  input  wire logic          sample_mode_hold,
  input  wire logic          input_clamp_strobe,
  input  wire logic          black_clamp_strobe,
  input  wire logic          pixel_strobe,
  input  wire logic [DW-1:0] adc_even,
  input  wire logic [DW-1:0] adc_odd,
  output logic [DW-1:0]      data_out,
  output logic               input_clamp_on,
  output logic               black_loop_on,
  output logic               standby
);

  ////////////////////////////////////////////////////////////////////////
  // link domain: shifter, strobe edge, readback
  logic [15:0]    shift_ff;
  logic [15:0]    nxt_shift;
  logic           wrt_q_ff;
  logic [9:0]     rd_sh_ff;
  afesc_link_st_t lst_ff;
  logic           wr_tog_ff;
  afesc_frame_t   wr_frm_ff;
  logic [9:0]     rd_snap_ff;
  logic [9:0]     rd_sel;
  afesc_frame_t   cur_frm;

  assign nxt_shift = {shift_ff[14:0], serial_data_in};
  assign cur_frm   = afesc_frame_t'(shift_ff);

  // link reset shares rst_n; host keeps the clock running while it resets
  always_ff @(posedge serial_clk) begin
    if (!rst_n) begin
      shift_ff <= 16'h0000;
    end else begin
      shift_ff <= nxt_shift;
    end
  end

  // strobe sampled on serial clock; a rise latches the last 16 bits, or starts a readback if their read flag is set
  logic wrt_rise;
  assign wrt_rise = write_strobe & ~wrt_q_ff;

  always_ff @(posedge serial_clk) begin
    if (!rst_n) begin
      wrt_q_ff  <= 1'b0;
      lst_ff    <= AFESC_ST_IDLE;
      wr_tog_ff <= 1'b0;
      wr_frm_ff <= '0;
      rd_sh_ff  <= 10'h000;
    end else begin
      wrt_q_ff <= write_strobe;
      case (lst_ff)
        AFESC_ST_IDLE: begin
          if (wrt_rise && cur_frm.rd_flag) begin
            lst_ff   <= AFESC_ST_READ;
            rd_sh_ff <= rd_sel;
          end else if (wrt_rise) begin
            wr_frm_ff <= cur_frm;
            wr_tog_ff <= ~wr_tog_ff;
          end
        end
        AFESC_ST_READ: begin
          rd_sh_ff <= {rd_sh_ff[8:0], 1'b0};
          if (!write_strobe) begin
            lst_ff <= AFESC_ST_IDLE;
          end
        end
        default: lst_ff <= AFESC_ST_IDLE;
      endcase
    end
  end

  assign read_output_pin = (lst_ff == AFESC_ST_READ) ? rd_sh_ff[9] : 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // crossing: write event toggle and register snapshot
  logic [2:0]  tog_sync_ff;
  logic [1:0]  ca_s1_ff;
  logic [1:0]  ca_s2_ff;
  logic        wr_event;
  logic [9:0]  regs_ff [8];
  logic [79:0] regs_flat;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tog_sync_ff <= 3'h0;
      ca_s1_ff    <= 2'h0;
      ca_s2_ff    <= 2'h0;
    end else begin
      tog_sync_ff <= {tog_sync_ff[1:0], wr_tog_ff};
      ca_s1_ff    <= {chip_select_pin_high, chip_select_pin_low};
      ca_s2_ff    <= ca_s1_ff;
    end
  end

  // frame stays stable for many sys clocks after the toggle, so it is read directly
  assign wr_event = tog_sync_ff[2] ^ tog_sync_ff[1];

  // readback copy: loaded only after the system side reports a finished write,
  // so the 80-bit word is already stable when the link side takes it
  logic        wr_done_ff;
  logic [2:0]  done_sync_ff;
  logic        snap_load;
  logic [79:0] snap_ff;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_done_ff <= 1'b0;
    end else begin
      wr_done_ff <= wr_done_ff ^ wr_event;
    end
  end

  assign snap_load = done_sync_ff[2] ^ done_sync_ff[1];

  always_ff @(posedge serial_clk) begin
    if (!rst_n) begin
      done_sync_ff <= 3'h0;
      snap_ff      <= {`AFESC_RST_MON, `AFESC_RST_TEST, `AFESC_RST_CLMP, `AFESC_RST_CLMP,
                       `AFESC_RST_GAIN, `AFESC_RST_GAIN, `AFESC_RST_STBY, `AFESC_RST_CFG};
    end else begin
      done_sync_ff <= {done_sync_ff[1:0], wr_done_ff};
      if (snap_load) begin
        snap_ff <= regs_flat;
      end
    end
  end
  assign rd_sel = snap_ff[cur_frm.addr*10 +: 10];

  ////////////////////////////////////////////////////////////////////////
  // register file
  logic [9:0] wr_mask [8];
  logic [9:0] rst_val [8];
  logic       wr_ok;
  assign wr_ok = wr_event & (wr_frm_ff.chip == ca_s2_ff) & ~wr_frm_ff.rd_flag;

  assign wr_mask[0] = `AFESC_MASK_CFG;
  assign wr_mask[1] = `AFESC_MASK_STBY;
  assign wr_mask[2] = `AFESC_MASK_GAIN;
  assign wr_mask[3] = `AFESC_MASK_GAIN;
  assign wr_mask[4] = `AFESC_MASK_CLMP;
  assign wr_mask[5] = `AFESC_MASK_CLMP;
  assign wr_mask[6] = `AFESC_MASK_TEST;
  assign wr_mask[7] = `AFESC_MASK_MON;
  assign rst_val[0] = `AFESC_RST_CFG;
  assign rst_val[1] = `AFESC_RST_STBY;
  assign rst_val[2] = `AFESC_RST_GAIN;
  assign rst_val[3] = `AFESC_RST_GAIN;
  assign rst_val[4] = `AFESC_RST_CLMP;
  assign rst_val[5] = `AFESC_RST_CLMP;
  assign rst_val[6] = `AFESC_RST_TEST;
  assign rst_val[7] = `AFESC_RST_MON;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_reg
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          regs_ff[gi] <= rst_val[gi];
        end else if (wr_ok && wr_frm_ff.addr == 3'(gi)) begin
          regs_ff[gi] <= wr_frm_ff.data & wr_mask[gi];
        end
      end
      assign regs_flat[gi*10 +: 10] = regs_ff[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // pixel path: clamp gating, black loop, gain, test pattern
  logic [9:0] cfg;
  logic [9:0] tst;
  assign cfg = regs_ff[`AFESC_RA_CFG];
  assign tst = regs_ff[`AFESC_RA_TEST];
  assign standby = regs_ff[`AFESC_RA_STBY][`AFESC_BIT_STBY];

  logic [4:0] sync_in_ff;
  logic [4:0] sync_q_ff;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync_in_ff <= 5'h00;
      sync_q_ff  <= 5'h00;
    end else begin
      sync_in_ff <= {pixel_strobe, sample_mode_hold, reference_sample_pulse,
                     data_sample_pulse, input_clamp_strobe};
      sync_q_ff  <= sync_in_ff;
    end
  end

  // strobe polarities: 0 = active low
  logic clp_act;
  logic ob_act;
  logic smp_act;
  logic pix_now;
  logic pix_q_ff;
  assign clp_act = sync_q_ff[0] ~^ cfg[`AFESC_BIT_CLPPOL];
  assign smp_act = (sync_q_ff[3] ? sync_q_ff[1] : sync_q_ff[2]) ~^ cfg[`AFESC_BIT_SMPPOL];
  assign input_clamp_on = clp_act & smp_act & ~standby;

  logic ob_s1_ff;
  logic ob_s2_ff;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ob_s1_ff <= 1'b0;
      ob_s2_ff <= 1'b0;
      pix_q_ff <= 1'b0;
    end else begin
      ob_s1_ff <= black_clamp_strobe;
      ob_s2_ff <= ob_s1_ff;
      pix_q_ff <= sync_q_ff[4];
    end
  end
  assign ob_act = ob_s2_ff ~^ cfg[`AFESC_BIT_OBPOL];
  assign black_loop_on = ob_act & ~standby;
  assign pix_now = sync_q_ff[4] & ~pix_q_ff & ~standby;

  // black loop: offset tracked only while loop strobe active
  logic [DW-1:0] offs_ff [2];
  logic [DW-1:0] clamped [2];
  logic [DW+9:0] gained  [2];
  logic [DW-1:0] gsat    [2];
  logic [DW:0]   gsum    [2];
  logic [DW-1:0] raw     [2];
  logic [DW-1:0] blk     [2];
  assign raw[0] = adc_even;
  assign raw[1] = adc_odd;

  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      assign blk[gi] = DW'({regs_ff[`AFESC_RA_CLMP_E+gi][7:0], 1'b0});
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          offs_ff[gi] <= '0;
        end else if (black_loop_on && pix_now) begin
          offs_ff[gi] <= raw[gi];
        end
      end
      assign clamped[gi] = raw[gi] - offs_ff[gi];
      // gain after the loop: black level added back after scaling
      assign gained[gi] = clamped[gi] * regs_ff[`AFESC_RA_GAIN_E+gi];
      // sum kept one bit wider so a high black level saturates instead of wrapping
      assign gsum[gi] = {1'b0, gained[gi][DW+5:6]} + {1'b0, blk[gi]};
      assign gsat[gi] = (|gained[gi][DW+9:DW+6] || gsum[gi][DW]) ? {DW{1'b1}}
                      : gsum[gi][DW-1:0];
    end
  endgenerate

  // test pattern: stripe width 8<<n, gradation step 2<<n
  logic [6:0]    run_ff;
  logic          phase_ff;
  logic [DW-1:0] grad_ff;
  logic [6:0]    stripe_len;
  logic [DW-1:0] grad_step;
  logic [DW-1:0] grad_nxt;
  logic [DW:0]   grad_sum;
  assign stripe_len = 7'h08 << tst[5:4];
  assign grad_step  = DW'(12'h002 << tst[5:4]);
  assign grad_sum   = {1'b0, grad_ff} + {1'b0, grad_step};
  assign grad_nxt   = (grad_sum > `AFESC_GRAD_MAX) ? `AFESC_GRAD_MIN : grad_sum[DW-1:0];

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      run_ff   <= 7'h00;
      phase_ff <= 1'b0;
      grad_ff  <= `AFESC_GRAD_MIN;
    end else if (pix_now) begin
      grad_ff <= grad_nxt;
      if (run_ff + 7'h01 >= stripe_len) begin
        run_ff   <= 7'h00;
        phase_ff <= ~phase_ff;
      end else begin
        run_ff <= run_ff + 7'h01;
      end
    end
  end

  logic          odd_first;
  logic          sel_odd_ff;
  logic [DW-1:0] pat;
  logic [DW-1:0] live;
  assign odd_first = cfg[`AFESC_BIT_ORDER];
  assign pat = tst[`AFESC_BIT_TSEL] ? (phase_ff ? blk[0] + `AFESC_STRIPE_ADD : blk[0])
                                    : grad_ff;
  assign live = (sel_odd_ff ^ odd_first) ? gsat[1] : gsat[0];

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      data_out   <= '0;
      sel_odd_ff <= 1'b0;
    end else if (pix_now) begin
      sel_odd_ff <= ~sel_odd_ff;
      data_out   <= tst[`AFESC_BIT_TEN] ? pat : live;
    end
  end

  a_wr_chip_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_event && wr_frm_ff.chip != ca_s2_ff) |=> $stable(regs_flat))
    else $error("write took effect with wrong chip address");
  a_read_no_write: assert property (@(posedge serial_clk) disable iff (!rst_n)
    (lst_ff == AFESC_ST_READ || (wrt_rise && cur_frm.rd_flag)) |=> $stable(wr_tog_ff))
    else $error("write issued during readback");
  a_clamp_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    input_clamp_on |-> !standby && sync_q_ff[0] == cfg[`AFESC_BIT_CLPPOL] &&
      (sync_q_ff[3] ? sync_q_ff[1] : sync_q_ff[2]) == cfg[`AFESC_BIT_SMPPOL])
    else $error("input clamp without both strobes");
  a_loop_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !ob_act |=> $stable(offs_ff[0]) && $stable(offs_ff[1]))
    else $error("black offset moved outside strobe");
  a_test_output: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pix_now && tst[0]) |=> data_out == $past(pat))
    else $error("test pattern not on output");
  a_grad_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
    grad_ff >= `AFESC_GRAD_MIN && grad_ff <= `AFESC_GRAD_MAX)
    else $error("gradation out of range");
  a_standby_halt: assert property (@(posedge clk_sys) disable iff (!rst_n)
    standby |-> (!black_loop_on && !pix_now) ##1 $stable(data_out))
    else $error("activity in standby");
  a_reset_default: assert property (@(posedge clk_sys)
    !rst_n |=> regs_ff[4] == `AFESC_RST_CLMP && regs_ff[2] == `AFESC_RST_GAIN)
    else $error("reset default wrong");
  a_read_shift: assert property (@(posedge serial_clk) disable iff (!rst_n)
    (lst_ff == AFESC_ST_READ && $past(lst_ff) == AFESC_ST_READ) |->
      rd_sh_ff == ($past(rd_sh_ff) << 1))
    else $error("readback not shifting");
  a_read_entry: assert property (@(posedge serial_clk) disable iff (!rst_n)
    (lst_ff == AFESC_ST_IDLE && wrt_rise && cur_frm.rd_flag) |=>
      lst_ff == AFESC_ST_READ && rd_sh_ff == $past(rd_sel))
    else $error("readback request not taken");
  a_rd_pin_idle: assert property (@(posedge serial_clk) disable iff (!rst_n)
    (lst_ff == AFESC_ST_IDLE) |-> !read_output_pin)
    else $error("read pin active outside readback");
  a_grad_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pix_now |=> grad_ff == `AFESC_GRAD_MIN || grad_ff == $past(grad_ff) + $past(grad_step))
    else $error("gradation step wrong");
  a_stripe_value: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pix_now && tst[`AFESC_BIT_TEN] && tst[`AFESC_BIT_TSEL]) |=>
      data_out == $past(blk[0]) || data_out == $past(blk[0]) + `AFESC_STRIPE_ADD)
    else $error("stripe level wrong");

endmodule

// >>> hw/afesc_consts.svh
// constants and function list of the serial control register block
`ifndef AFESC_CONSTS_SVH
`define AFESC_CONSTS_SVH
`define AFESC_FRAME_BITS   16
`define AFESC_RA_CFG       3'h0
`define AFESC_RA_STBY      3'h1
`define AFESC_RA_GAIN_E    3'h2
`define AFESC_RA_GAIN_O    3'h3
`define AFESC_RA_CLMP_E    3'h4
`define AFESC_RA_CLMP_O    3'h5
`define AFESC_RA_TEST      3'h6
`define AFESC_RA_MON       3'h7
`define AFESC_MASK_CFG     10'h0d7
`define AFESC_MASK_STBY    10'h3fd
`define AFESC_MASK_GAIN    10'h3ff
`define AFESC_MASK_CLMP    10'h0ff
`define AFESC_MASK_TEST    10'h035
`define AFESC_MASK_MON     10'h002
`define AFESC_RST_CFG      10'h000
`define AFESC_RST_STBY     10'h220
`define AFESC_RST_GAIN     10'h040
`define AFESC_RST_CLMP     10'h050
`define AFESC_RST_TEST     10'h000
`define AFESC_RST_MON      10'h000
`define AFESC_BIT_STBY     0
`define AFESC_BIT_TEN      0
`define AFESC_BIT_TSEL     2
`define AFESC_BIT_TIVL     4
`define AFESC_BIT_CLPPOL   0
`define AFESC_BIT_OBPOL    1
`define AFESC_BIT_SMPPOL   2
`define AFESC_BIT_ORDER    4
`define AFESC_STRIPE_ADD   12'h080
`define AFESC_GRAD_MIN     12'h001
`define AFESC_GRAD_MAX     12'hfff
`define AFESC_GAIN_SHIFT   6
`endif

// >>> hw/afesc_pkg.sv
// types of the serial control register block
package afesc_pkg;
  typedef struct packed {
    logic [1:0] chip;
    logic       rd_flag;
    logic [2:0] addr;
    logic [9:0] data;
  } afesc_frame_t;
  typedef struct packed {
    logic       valid;
    logic [2:0] addr;
    logic [9:0] data;
  } afesc_wr_t;
  typedef enum logic [1:0] {
    AFESC_ST_IDLE = 2'b01,
    AFESC_ST_READ = 2'b10
  } afesc_link_st_t;
endpackage

// >>> tb/afesc_host.sv
// host side model of the three-wire serial control port
`timescale 1ns/10ps
module afesc_host
  import afesc_pkg::*;
(
  output logic      serial_clk,
  output logic      serial_data_in,
  output logic      write_strobe,
  input  wire logic read_output_pin
);
  logic rd_s;
  initial begin
    serial_clk = 1'b0;
    serial_data_in = 1'b0;
    write_strobe = 1'b0;
    rd_s = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // data set while clock low, read pin taken just before the fall
  task automatic tick(input logic d);
    serial_data_in = d;
    #7.5 serial_clk = 1'b1;
    #7.0 rd_s = read_output_pin;
    #0.5 serial_clk = 1'b0;
  endtask
  // clock only runs in frames, or while reset needs edges
  task automatic idle(input int n);
    repeat (n) tick(~serial_data_in);
  endtask
  task automatic shift(input afesc_frame_t f, input int pre);
    for (int i = 0; i < pre; i++) tick(i[0]);
    for (int i = 15; i >= 0; i--) tick(f[i]);
  endtask
  task automatic wr(input afesc_frame_t f, input int pre);
    shift(f, pre);
    write_strobe = 1'b1;
    tick(~f[0]);
    write_strobe = 1'b0;
    tick(f[0]);
  endtask
  // data bits of the request are fed again as junk while reading
  task automatic rd(input afesc_frame_t f, output logic [9:0] v);
    shift(f, 0);
    write_strobe = 1'b1;
    tick(~f[0]);
    v[9] = rd_s;
    for (int i = 8; i >= 0; i--) begin
      tick(f.data[i]);
      v[i] = rd_s;
    end
    write_strobe = 1'b0;
    tick(~f[0]);
  endtask
endmodule

// >>> tb/afesc_top_bench.sv
// self-checking bench of the serial control register block
`timescale 1ns/10ps
`include "afesc_consts.svh"
module afesc_top_bench
  import afesc_pkg::*;
;
  logic        clk_sys, rst_n, serial_clk, serial_data_in, write_strobe, read_output_pin;
  logic        csl, csh, ref_p, dat_p, hold, iclp, bclp, pix, iclp_on, bl_on, stby;
  logic        pol, act;
  logic [11:0] adc_e, adc_o, data_out, v, lo, hi, prev;
  logic [1:0]  chip;
  logic [9:0]  mdl [8];
  int          bad_count, samples_checked, e, n_hi, n_sw, run;
  logic [9:0]  msk [8] = '{`AFESC_MASK_CFG, `AFESC_MASK_STBY, `AFESC_MASK_GAIN,
    `AFESC_MASK_GAIN, `AFESC_MASK_CLMP, `AFESC_MASK_CLMP, `AFESC_MASK_TEST, `AFESC_MASK_MON};
  logic [9:0]  dflt [8] = '{`AFESC_RST_CFG, `AFESC_RST_STBY, `AFESC_RST_GAIN,
    `AFESC_RST_GAIN, `AFESC_RST_CLMP, `AFESC_RST_CLMP, `AFESC_RST_TEST, `AFESC_RST_MON};
  assign chip = {csh, csl};
  afesc_top uut (
    .clk_sys                (clk_sys),
    .rst_n                  (rst_n),
    .serial_clk             (serial_clk),
    .serial_data_in         (serial_data_in),
    .write_strobe           (write_strobe),
    .chip_select_pin_low    (csl),
    .chip_select_pin_high   (csh),
    .read_output_pin        (read_output_pin),
    .reference_sample_pulse (ref_p),
    .data_sample_pulse      (dat_p),
    .sample_mode_hold       (hold),
    .input_clamp_strobe     (iclp),
    .black_clamp_strobe     (bclp),
    .pixel_strobe           (pix),
    .adc_even               (adc_e),
    .adc_odd                (adc_o),
    .data_out               (data_out),
    .input_clamp_on         (iclp_on),
    .black_loop_on          (bl_on),
    .standby                (stby)
  );
  afesc_host host (
    .serial_clk      (serial_clk),
    .serial_data_in  (serial_data_in),
    .write_strobe    (write_strobe),
    .read_output_pin (read_output_pin)
  );
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [11:0] x, input logic [11:0] s);
    samples_checked++;
    if (s !== x) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask
  // serial clock must run while reset is low
  task automatic do_reset();
    @(negedge clk_sys);
    rst_n = 1'b0;
    fork
      repeat (4) @(negedge clk_sys);
      host.idle(12);
    join
    @(negedge clk_sys);
    rst_n = 1'b1;
    mdl = dflt;
    repeat (4) @(negedge clk_sys);
  endtask
  // spacing keeps clear of the snapshot lag and the write spacing
  task automatic wreg(input logic [1:0] c, input int a, input logic [9:0] d, input int pre);
    host.wr({c, 1'b0, a[2:0], d}, pre);
    if (c === chip) mdl[a] = d & msk[a];
    repeat (10) @(negedge clk_sys);
  endtask
  task automatic rchk(input int a);
    logic [9:0] r;
    host.rd({chip, 1'b1, a[2:0], 10'($urandom)}, r);
    chk("readback", 12'(mdl[a]), 12'(r));
    repeat (10) @(negedge clk_sys);
  endtask
  task automatic rall();
    for (int a = 0; a < 8; a++) rchk(a);
  endtask
  // one pixel: strobe up three clocks, data taken after it settles
  task automatic pixel(output logic [11:0] p);
    pix = 1'b1;
    adc_e = 12'($urandom);
    adc_o = 12'($urandom);
    repeat (3) @(negedge clk_sys);
    pix = 1'b0;
    repeat (3) @(negedge clk_sys);
    p = data_out;
  endtask
  initial begin
    #2ms;
    bad_count++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    bad_count = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    {csl, csh, ref_p, dat_p, hold, iclp, bclp, pix} = 8'h00;
    adc_e = 12'h000;
    adc_o = 12'h000;
    void'($urandom(66));
    {csh, csl} = 2'($urandom);
    do_reset();
    rall();
    for (int a = 0; a < 8; a++) begin
      wreg(chip, a, 10'($urandom), 0);
      rchk(a);
    end
    wreg(chip ^ 2'h1, 2, 10'($urandom), 0);
    rchk(2);
    wreg(chip, 3, 10'($urandom), 5);
    rchk(3);
    wreg(chip, 1, 10'h221, 0);
    chk("standby", 12'h001, 12'(stby));
    rchk(1);
    wreg(chip, 1, 10'h220, 0);
    chk("standby", 12'h000, 12'(stby));
    // polarity of strobes and pulses flipped for the upper half
    for (int k = 0; k < 16; k++) begin
      if (k % 8 == 0) wreg(chip, 0, (k == 8) ? 10'h007 : 10'h000, 0);
      {pol, hold, ref_p, iclp} = 4'(k);
      dat_p = ~ref_p;
      bclp = iclp ^ hold;
      repeat (5) @(negedge clk_sys);
      act = hold ? dat_p : ref_p;
      chk("input_clamp_on", 12'(iclp == pol && act == pol), 12'(iclp_on));
      chk("black_loop_on", 12'(bclp == pol), 12'(bl_on));
    end
    for (int t = 0; t < 4; t += 3) begin
      wreg(chip, 6, 10'(t << 4) | 10'h001, 0);
      pixel(v);
      for (int p = 0; p < 300; p++) begin
        e = int'(v) + (2 << t);
        if (e > 4095) e = 1;
        pixel(v);
        chk("gradation", 12'(e), v);
      end
    end
    wreg(chip, 6, 10'h005, 0);
    lo = 12'(mdl[4]) << 1;
    hi = lo + 12'h080;
    n_hi = 0;
    n_sw = 0;
    run = 0;
    for (int p = 0; p < 40; p++) begin
      pixel(v);
      if (v === hi) n_hi++;
      if (p > 0 && v !== prev) begin
        if (n_sw > 0) chk("stripe_run", 12'h008, 12'(run));
        n_sw++;
        run = 0;
      end
      run++;
      prev = v;
      chk("stripe", (v === hi) ? hi : lo, v);
    end
    chk("stripe_high_seen", 12'h001, 12'(n_hi > 0 && n_sw > 1));
    wreg(chip, 6, 10'h000, 0);
    do_reset();
    rall();
    wrap_up();
  end
endmodule
